// [design/serial_rate_gen.sv]
// Half-period tick source for the master serial clock.
// Assumes run drops between transfers so every counter-timed byte starts a fresh half period; the timer option keeps the timer_pulse phase.
`timescale 1ns/1ps

module serial_rate_gen #(
    parameter int CW = 10
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic run,
    input wire logic use_timer,
    input wire logic timer_pulse,
    input wire logic [CW-1:0] half_len,
    output logic tick
);
    logic [CW-1:0] count;
    wire logic count_end = (count == half_len - {{(CW-1){1'b0}}, 1'b1});

    // Timer option toggles once per timer pulse, which halves its rate
    assign tick = run & (use_timer ? timer_pulse : count_end); // RULE_21

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count <= '0;
        end else if (!run || count_end) begin
            count <= '0;
        end else begin
            count <= count + {{(CW-1){1'b0}}, 1'b1};
        end
    end

    property p_div4_spacing;
        @(posedge pclk) disable iff (!presetn)
        (tick && !use_timer && half_len == 10'h002 && run) ##1 run |-> !tick ##1 (tick || !run);
    endproperty
    a_div4_spacing: assert property (p_div4_spacing) else $error("fast rate spacing wrong"); // RULE_21
endmodule

// [design/sync_serial_port.sv]
// SPI engine of the synchronous serial port with its APB register file.
// Assumes pin inputs are already synchronous to pclk; pads are built outside.
//
// The APB slave port and the placing of the registers were decided locally.
`timescale 1ns/1ps

module sync_serial_port (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [sync_serial_port_pkg::ADDR_W-1:0] paddr,
    input wire logic [sync_serial_port_pkg::DATA_W-1:0] pwdata,
    output logic [sync_serial_port_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic sck_in,
    output logic sck_out,
    output logic sck_oe,
    input wire logic sdi,
    output logic sdo_out,
    output logic sdo_oe,
    input wire logic ss_n,
    input wire logic timer_pulse,
    output logic irq_flag
);
    import sync_serial_port_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // Register state

    logic [7:0] serial_shift_reg;
    logic [7:0] serial_data_buffer;
    logic [7:0] serial_rate_reload;
    logic [7:0] serial_control_three;
    logic [6:0] ctl1_bits;
    logic write_collision_flag;
    logic buffer_full_flag;
    logic serial_irq_flag;
    logic stat_smp;
    logic stat_cke;
    logic sck_level;
    logic sck_prev;
    logic sdo_reg;
    logic busy;
    logic [2:0] bit_count;
    logic [3:0] half_count;

    ////////////////////////////////////////////////////////////////////////////////
    // APB decode

    wire logic access = psel & penable;
    wire logic wr = access & pwrite;
    wire logic rd = access & ~pwrite;
    wire logic hit_status = (paddr == OFF_STATUS);
    wire logic hit_ctl1 = (paddr == OFF_CTL1);
    wire logic hit_ctl3 = (paddr == OFF_CTL3);
    wire logic hit_data = (paddr == OFF_DATA);
    wire logic hit_reload = (paddr == OFF_RELOAD);
    wire logic hit_flag = (paddr == OFF_FLAG);
    wire logic mapped = hit_status | hit_ctl1 | hit_ctl3 | hit_data | hit_reload | hit_flag;

    wire logic status_wr = wr & hit_status;
    wire logic ctl1_wr = wr & hit_ctl1;
    wire logic buf_wr = wr & hit_data;
    wire logic buf_rd = rd & hit_data;
    wire logic flag_wr = wr & hit_flag;

    ////////////////////////////////////////////////////////////////////////////////
    // Mode decode

    wire logic [3:0] mode = ctl1_bits[3:0];
    wire logic port_en = ctl1_bits[CTL_EN];
    wire logic ckp = ctl1_bits[CTL_CKP];
    wire logic is_master = (mode == MODE_DIV4) | (mode == MODE_DIV16) | (mode == MODE_DIV64)
                         | (mode == MODE_TIMER) | (mode == MODE_RELOAD);
    wire logic ss_mode = (mode == MODE_SLAVE_SS);
    wire logic is_slave = ss_mode | (mode == MODE_SLAVE);
    wire logic master_on = port_en & is_master;
    wire logic slave_on = port_en & is_slave;
    // Without select control the slave is always listening and may drift by a bit
    wire logic selected = ~ss_mode | ~ss_n; // RULE_22
    wire logic slave_live = slave_on & selected; // RULE_09

    // Reload option: clock over 4*(reload+1), so half period is 2*(reload+1)
    wire logic [HALF_W-1:0] reload_half = {1'b0, serial_rate_reload, 1'b0} + HALF_STEP; // RULE_16
    wire logic [HALF_W-1:0] half_len = (mode == MODE_DIV16) ? HALF_DIV16 :
                                       (mode == MODE_DIV64) ? HALF_DIV64 :
                                       (mode == MODE_RELOAD) ? reload_half :
                                       HALF_DIV4; // RULE_21
    wire logic rate_tick;

    serial_rate_gen #(
        .CW(HALF_W)
    ) rate_gen (
        .pclk(pclk),
        .presetn(presetn),
        .run(busy),
        .use_timer(mode == MODE_TIMER),
        .timer_pulse(timer_pulse),
        .half_len(half_len),
        .tick(rate_tick)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Edge classification

    // Master: even half ticks leave idle, odd ones return to idle
    wire logic master_edge = master_on & busy & rate_tick; // RULE_06
    wire logic slave_edge = slave_live & (sck_in != sck_prev); // RULE_09
    wire logic edge_ev = master_edge | slave_edge;
    wire logic leading = master_on ? ~half_count[0] : (sck_in != ckp);
    // Edge select: with cke set data moves on the return to idle
    wire logic sample = edge_ev & (stat_cke ? leading : ~leading); // RULE_03
    wire logic shift = edge_ev & ~sample; // RULE_03
    wire logic [7:0] shifted = {serial_shift_reg[6:0], sdi}; // RULE_02 RULE_04
    wire logic done = sample & (bit_count == LAST_BIT); // RULE_05
    wire logic in_xfer = master_on ? busy : (slave_on & (bit_count != 3'h0));
    // Collision check covers the master's busy time but a slave only from its first sampled bit to its eighth
    wire logic collide = buf_wr & in_xfer; // RULE_19
    wire logic buf_load = buf_wr & ~in_xfer & ~write_collision_flag; // RULE_19
    wire logic start = buf_load & master_on;
    wire logic slave_drop = slave_on & ss_mode & ss_n;
    wire logic last_half = master_edge & (half_count == LAST_HALF);

    ////////////////////////////////////////////////////////////////////////////////
    // Shift path

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            serial_shift_reg <= RST_BYTE;
        end else if (buf_load) begin
            serial_shift_reg <= pwdata[7:0]; // RULE_13 RULE_11
        end else if (sample) begin
            serial_shift_reg <= shifted; // RULE_02 RULE_01
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sdo_reg <= 1'b0;
        end else if (buf_load) begin
            sdo_reg <= pwdata[7]; // RULE_02
        end else if (shift) begin
            sdo_reg <= serial_shift_reg[7]; // RULE_07
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bit_count <= 3'h0; // RULE_23
        end else if (!port_en || slave_drop || start) begin
            bit_count <= 3'h0;
        end else if (sample) begin
            bit_count <= bit_count + 3'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Master clock

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy <= 1'b0;
        end else if (!master_on || last_half) begin
            busy <= 1'b0;
        end else if (start) begin
            busy <= 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            half_count <= 4'h0;
        end else if (!busy) begin
            half_count <= 4'h0;
        end else if (master_edge) begin
            half_count <= half_count + 4'h1;
        end
    end

    // Idle level tracks polarity so a polarity change never glitches mid-byte
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sck_level <= 1'b0; // RULE_23
        end else if (!busy) begin
            sck_level <= ckp; // RULE_10
        end else if (master_edge) begin
            sck_level <= ~sck_level;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sck_prev <= 1'b0;
        end else begin
            sck_prev <= sck_in;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Registers and flags

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            serial_data_buffer <= RST_BYTE;
        end else if (done) begin
            serial_data_buffer <= shifted; // RULE_12
        end else if (buf_load) begin
            serial_data_buffer <= pwdata[7:0]; // RULE_13 RULE_17
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            buffer_full_flag <= 1'b0; // RULE_23
        end else if (done) begin
            buffer_full_flag <= 1'b1; // RULE_20
        end else if (buf_rd) begin
            buffer_full_flag <= 1'b0; // RULE_20
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            serial_irq_flag <= 1'b0;
        end else if (done) begin
            serial_irq_flag <= 1'b1; // RULE_12
        end else if (flag_wr && pwdata[FLAG_IRQ]) begin
            serial_irq_flag <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            write_collision_flag <= 1'b0;
        end else if (collide) begin
            write_collision_flag <= 1'b1; // RULE_19
        end else if (ctl1_wr) begin
            write_collision_flag <= pwdata[CTL_WRITE_COLLISION_FLAG]; // RULE_15
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl1_bits <= 7'h00;
            stat_smp <= 1'b0;
            stat_cke <= 1'b0;
            serial_control_three <= RST_BYTE;
            serial_rate_reload <= RST_BYTE;
        end else begin
            if (ctl1_wr) begin
                ctl1_bits <= pwdata[6:0]; // RULE_15 RULE_18
            end
            if (status_wr) begin
                stat_smp <= pwdata[STAT_SMP]; // RULE_14
                stat_cke <= pwdata[STAT_CKE]; // RULE_14
            end
            if (wr && hit_ctl3) begin
                serial_control_three <= pwdata[7:0];
            end
            if (wr && hit_reload) begin
                serial_rate_reload <= pwdata[7:0]; // RULE_16
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read mux and pins

    // Lower six status bits come from hardware only
    wire logic [7:0] status_view = {stat_smp, stat_cke, 5'h00, buffer_full_flag}; // RULE_14
    wire logic [7:0] read_byte = hit_status ? status_view :
                                 hit_ctl1 ? {write_collision_flag, ctl1_bits} :
                                 hit_ctl3 ? serial_control_three :
                                 hit_data ? serial_data_buffer :
                                 hit_reload ? serial_rate_reload :
                                 hit_flag ? {7'h00, serial_irq_flag} :
                                 8'h00;

    assign prdata = {24'h000000, read_byte};
    assign pready = 1'b1;
    assign pslverr = access & ~mapped;
    assign irq_flag = serial_irq_flag;
    assign sck_out = sck_level;
    assign sck_oe = master_on; // RULE_06
    assign sdo_out = sdo_reg;
    assign sdo_oe = master_on | slave_live; // RULE_09 RULE_22

    ////////////////////////////////////////////////////////////////////////////////
    // Checks

    property p_load_both;
        @(posedge pclk) disable iff (!presetn)
        buf_load |=> serial_shift_reg == $past(pwdata[7:0]) && sdo_out == $past(pwdata[7])
                     && serial_data_buffer == $past(pwdata[7:0]);
    endproperty
    a_load_both: assert property (p_load_both) else $error("buffer write not loaded"); // RULE_13

    property p_byte_lands;
        @(posedge pclk) disable iff (!presetn)
        done |=> buffer_full_flag && serial_irq_flag && bit_count == 3'h0
                 && serial_data_buffer == serial_shift_reg;
    endproperty
    a_byte_lands: assert property (p_byte_lands) else $error("received byte not posted"); // RULE_12

    property p_collision;
        @(posedge pclk) disable iff (!presetn)
        (buf_wr && in_xfer && !done) |=> write_collision_flag
                                         && serial_data_buffer == $past(serial_data_buffer);
    endproperty
    a_collision: assert property (p_collision) else $error("collision not flagged"); // RULE_19

    property p_blocked_write;
        @(posedge pclk) disable iff (!presetn)
        (buf_wr && write_collision_flag && !done) |=> serial_data_buffer == $past(serial_data_buffer);
    endproperty
    a_blocked_write: assert property (p_blocked_write) else $error("write passed collision"); // RULE_19

    property p_bf_read;
        @(posedge pclk) disable iff (!presetn)
        (buf_rd && !done) |=> !buffer_full_flag;
    endproperty
    a_bf_read: assert property (p_bf_read) else $error("buffer full not cleared"); // RULE_20

    property p_bf_ro;
        @(posedge pclk) disable iff (!presetn)
        (status_wr && !done && !buf_rd) |=> buffer_full_flag == $past(buffer_full_flag);
    endproperty
    a_bf_ro: assert property (p_bf_ro) else $error("status low bits written"); // RULE_14

    property p_unselected;
        @(posedge pclk) disable iff (!presetn)
        (ss_mode && ss_n && !master_on) |-> !sdo_oe ##1 (bit_count == 3'h0);
    endproperty
    a_unselected: assert property (p_unselected) else $error("unselected slave active"); // RULE_09

    property p_idle_clock;
        @(posedge pclk) disable iff (!presetn)
        (!busy && $past(!busy) && $stable(ckp)) |-> sck_out == ckp;
    endproperty
    a_idle_clock: assert property (p_idle_clock) else $error("clock not at idle level"); // RULE_23

    property p_eight_bits;
        @(posedge pclk) disable iff (!presetn)
        start |=> !done [*8];
    endproperty
    a_eight_bits: assert property (p_eight_bits) else $error("byte ended early"); // RULE_05

    property p_master_drive;
        @(posedge pclk) disable iff (!presetn)
        start |=> busy && sck_oe && sdo_oe;
    endproperty
    a_master_drive: assert property (p_master_drive) else $error("master did not start"); // RULE_06
endmodule

// [design/sync_serial_port_pkg.sv]
// Constants, offsets and field layout of the synchronous serial port (SPI role).
// Assumes an APB master with 32-bit data and byte addresses on paddr.
// How it works
// [RULE_01] Both ends hold one eight-bit shift register forming the exchange path.
// [RULE_02] Most significant bit leaves first; incoming bit enters the lowest position.
// [RULE_03] Output changes on the configured edge, input is taken on the other.
// [RULE_04] Each clock cycle moves one bit out and one bit in together.
// [RULE_05] Eight clocked bits swap the two shift registers completely.
// [RULE_06] The master drives the clock; both ends use the same polarity.
// [RULE_07] Each data output feeds the other party's data input.
// [RULE_08] A master drives one select line per slave, only one low at once.
// [RULE_09] An unselected slave ignores clock and data and leaves its output undriven.
// [RULE_10] Transfers take any length; the master then stops the clock and deselects.
// [RULE_11] Each side reloads its shift register before the next byte of clocks.
// [RULE_12] A completed byte is copied to the buffer and the interrupt flag set.
// [RULE_13] A buffer write loads buffer and shift register in the same cycle.
// [RULE_14] Status: lower six bits read-only, upper two bits read and write.
// [RULE_15] Control one is fully read/write and configures the port with status.
// [RULE_16] One master option derives the serial clock from the rate reload value.
// [RULE_17] The shift register is reached only through the data buffer.
// [RULE_18] Port runs one protocol at a time; this logic is the SPI one.
// [RULE_19] A write during shifting is dropped and sets the collision flag.
// [RULE_20] Buffer-full sets when a byte lands and clears on a buffer read.
// [RULE_21] Master rate: clock over 4, 16, 64, timer pulse halved, or reload divider.
// [RULE_22] Slave with select control moves and drives data only while select is low.
// [RULE_23] Reset parks the clock at idle, clears the bit count and buffer-full.

package sync_serial_port_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int HALF_W = 10;

    localparam logic [7:0] OFF_STATUS = 8'h00;
    localparam logic [7:0] OFF_CTL1 = 8'h04;
    localparam logic [7:0] OFF_CTL3 = 8'h08;
    localparam logic [7:0] OFF_DATA = 8'h0C;
    localparam logic [7:0] OFF_RELOAD = 8'h10;
    localparam logic [7:0] OFF_FLAG = 8'h14;

    localparam int STAT_SMP = 7;
    localparam int STAT_CKE = 6;
    localparam int STAT_BF = 0;
    localparam int CTL_WRITE_COLLISION_FLAG = 7;
    localparam int CTL_EN = 5;
    localparam int CTL_CKP = 4;
    localparam int FLAG_IRQ = 0;

    localparam logic [3:0] MODE_DIV4 = 4'h0;
    localparam logic [3:0] MODE_DIV16 = 4'h1;
    localparam logic [3:0] MODE_DIV64 = 4'h2;
    localparam logic [3:0] MODE_TIMER = 4'h3;
    localparam logic [3:0] MODE_SLAVE_SS = 4'h4;
    localparam logic [3:0] MODE_SLAVE = 4'h5;
    localparam logic [3:0] MODE_RELOAD = 4'hA;

    localparam logic [9:0] HALF_DIV4 = 10'h002;
    localparam logic [9:0] HALF_DIV16 = 10'h008;
    localparam logic [9:0] HALF_DIV64 = 10'h020;
    localparam logic [9:0] HALF_STEP = 10'h002;

    localparam logic [2:0] LAST_BIT = 3'h7;
    localparam logic [3:0] LAST_HALF = 4'hF;
    localparam logic [7:0] RST_BYTE = 8'h00;
endpackage

// [tb/spi_far_model.sv]
// Far-side SPI party: slave to the port as master, master to the port as slave.
// Assumes clock idle low and one byte per frame; sr is loaded by the bench.
`timescale 1ns/1ps

module spi_far_model (
    input wire logic pclk,
    input wire logic role_master,
    input wire logic sck_out,
    input wire logic sdo_out,
    input wire logic sdo_oe,
    output logic sck_in,
    output logic sdi
);
    logic [7:0] sr;
    logic sck_prev;
    logic last_sdo;
    wire sck = role_master ? sck_out : sck_in;
    // Released line shows the inverse, so a stale bit never passes
    wire seen_sdo = sdo_oe ? sdo_out : ~last_sdo;

    initial begin
        sr = 8'h00;
        sck_prev = 1'b0;
        last_sdo = 1'b0;
        sck_in = 1'b0;
        sdi = 1'b0;
    end

    always @(posedge pclk) begin
        sck_prev <= sck;
        if (sdo_oe) begin
            last_sdo <= sdo_out;
        end
        if (sck && !sck_prev) begin
            sdi <= sr[7];
        end
        if (!sck && sck_prev) begin
            sr <= {sr[6:0], seen_sdo};
        end
    end

    // Clock only within the frame; three cycles high keeps sampling clear
    task automatic clock_byte();
        repeat (8) begin
            @(posedge pclk);
            sck_in <= 1'b1;
            repeat (3) @(posedge pclk);
            sck_in <= 1'b0;
            repeat (2) @(posedge pclk);
        end
        repeat (3) @(posedge pclk);
    endtask
endmodule

// [tb/sync_serial_port_tb.sv]
// Self-checking bench of the serial port: APB register access and SPI traffic.
// Assumes zero-wait APB and the far-side model in spi_far_model.
`timescale 1ns/1ps

module sync_serial_port_tb;
    import sync_serial_port_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, ss_n, timer_pulse, role_m;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic pready, pslverr, sck_in, sck_out, sck_oe, sdi, sdo_out, sdo_oe, irq_flag;
    logic [32:0] exp_q[$];
    logic sck_prev;
    int mismatches, checks, cnt, gap, tcnt;

    sync_serial_port dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sck_in(sck_in), .sck_out(sck_out), .sck_oe(sck_oe), .sdi(sdi),
        .sdo_out(sdo_out), .sdo_oe(sdo_oe), .ss_n(ss_n), .timer_pulse(timer_pulse),
        .irq_flag(irq_flag));
    spi_far_model model (.pclk(pclk), .role_master(role_m), .sck_out(sck_out),
        .sdo_out(sdo_out), .sdo_oe(sdo_oe), .sck_in(sck_in), .sdi(sdi));

    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    ////////////////////////////////////////////////////////////////////
    task automatic check(input logic [32:0] seen, input logic [32:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict();
        $display("mismatches %0d checks %0d", mismatches, checks);
        if (mismatches == 0 && checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [32:0] e);
        exp_q.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask

    // Reads are judged where the access phase completes
    always @(posedge pclk) begin
        if (psel && penable && pready && !pwrite && exp_q.size() > 0) begin
            check({pslverr, prdata}, exp_q.pop_front());
        end
    end

    // Half period of the serial clock, as cycles between toggles
    always @(posedge pclk) begin
        sck_prev <= sck_out;
        tcnt <= (tcnt == 2) ? 0 : tcnt + 1;
        timer_pulse <= (tcnt == 2);
        if (sck_out !== sck_prev) begin
            gap <= cnt;
            cnt <= 1;
        end else begin
            cnt <= cnt + 1;
        end
    end

    task automatic xfer(input logic [3:0] mode, input int half, input logic coll);
        logic [7:0] tx, rx;
        int n;
        tx = 8'($urandom);
        rx = 8'($urandom);
        model.sr = rx;
        apb(1'b1, OFF_CTL1, {24'h0, 4'h2, mode});
        apb(1'b1, OFF_DATA, {24'h0, tx});
        if (coll) begin
            repeat (10) @(posedge pclk);
            apb(1'b1, OFF_DATA, {24'h0, ~tx});
        end
        n = 0;
        while (irq_flag !== 1'b1 && n < 5000) begin
            @(posedge pclk);
            n++;
        end
        check(irq_flag, 1'b1);
        // Far side takes the last bit one edge after the port's last edge
        repeat (2) @(posedge pclk);
        check(gap, half);
        check(model.sr, tx);
        check({sck_oe, sck_out}, 2'b10);
        rd(OFF_STATUS, 33'h1);
        rd(OFF_DATA, rx);
        rd(OFF_STATUS, 33'h0);
        rd(OFF_FLAG, 33'h1);
        apb(1'b1, OFF_FLAG, 32'h1);
        rd(OFF_FLAG, 33'h0);
        if (coll) begin
            rd(OFF_CTL1, {25'h0, 1'b1, 3'h2, mode});
            apb(1'b1, OFF_CTL1, {24'h0, 4'h2, mode});
        end
    endtask

    ////////////////////////////////////////////////////////////////////
    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {mismatches, checks, cnt, gap, tcnt} = '0;
        ss_n = 1'b1;
        role_m = 1'b1;
        timer_pulse = 1'b0;
        sck_prev = 1'b0;
        presetn = 1'b0;
        void'($urandom(32'h8210));
        repeat (10) @(posedge pclk);
        check({irq_flag, sck_out, sck_oe, sdo_oe}, 4'h0);
        presetn <= 1'b1;
        rd(OFF_STATUS, 33'h0);
        rd(OFF_CTL1, 33'h0);
        apb(1'b1, OFF_STATUS, 32'hFF);
        rd(OFF_STATUS, 33'hC0);
        apb(1'b1, OFF_STATUS, 32'h0);
        apb(1'b1, OFF_CTL1, 32'h5F);
        rd(OFF_CTL1, 33'h5F);
        apb(1'b1, OFF_CTL3, 32'hA5);
        rd(OFF_CTL3, 33'hA5);
        apb(1'b1, OFF_RELOAD, 32'h1);
        rd(OFF_RELOAD, 33'h1);
        rd(8'h18, 33'h100000000);
        apb(1'b1, OFF_CTL1, 32'h0);
        apb(1'b1, OFF_DATA, 32'h5A);
        rd(OFF_DATA, 33'h5A);
        xfer(MODE_DIV4, 2, 1'b0);
        xfer(MODE_DIV16, 8, 1'b0);
        xfer(MODE_DIV64, 32, 1'b1);
        xfer(MODE_RELOAD, 4, 1'b0);
        xfer(MODE_TIMER, 3, 1'b0);
        role_m <= 1'b0;
        apb(1'b1, OFF_CTL1, {24'h0, 4'h2, MODE_SLAVE_SS});
        apb(1'b1, OFF_DATA, 32'hC3);
        model.sr = 8'h96;
        model.clock_byte();
        check({sdo_oe, irq_flag}, 2'b00);
        ss_n <= 1'b0;
        apb(1'b1, OFF_DATA, 32'h3C);
        model.sr = 8'h69;
        check(sdo_oe, 1'b1);
        model.clock_byte();
        check({irq_flag, model.sr}, 9'h13C);
        rd(OFF_DATA, 33'h69);
        ss_n <= 1'b1;
        apb(1'b1, OFF_FLAG, 32'h1);
        apb(1'b1, OFF_CTL1, {24'h0, 4'h2, MODE_SLAVE});
        apb(1'b1, OFF_DATA, 32'hA5);
        model.sr = 8'h5A;
        check(sdo_oe, 1'b1);
        model.clock_byte();
        check({irq_flag, model.sr}, 9'h1A5);
        rd(OFF_DATA, 33'h5A);
        @(posedge pclk);
        print_verdict();
    end

    initial begin
        repeat (60000) @(posedge pclk);
        mismatches++;
        print_verdict();
    end
endmodule
